// File: cgs_clock_select.sv
// Interrupt enable and clock source / wait behaviour select logic.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`include "cgs_regs.svh"
module cgs_clock_select
    import cgs_pkg::*;
(
    input  wire logic       sys_clk_in,      // Bus clock, 40 MHz.
    input  wire logic       rst_n_in,        // Asynchronous active-low reset.
    input  wire logic [3:0] addr_in,         // Register address.
    input  wire logic [7:0] wdata_in,        // Write data.
    input  wire logic       wr_in,           // Write strobe.
    input  wire logic       rd_in,           // Read strobe.
    input  wire logic       settled_in,      // Synthesizer lock status.
    input  wire logic       tracking_in,     // Synthesizer track status.
    input  wire logic       auto_bw_in,      // Auto bandwidth bit from synth control.
    input  wire logic       fallback_in,     // Fallback clock status.
    input  wire logic       tick_event_in,   // One-cycle tick period end.
    input  wire logic       enter_wait_in,   // Pulse on wait mode entry.
    input  wire logic       enter_stop_in,   // Pulse on stop mode entry.
    input  wire logic       exit_low_in,     // Pulse on wait or stop exit.
    input  wire logic       special_mode_in, // High in special modes.
    output logic [7:0]      rdata_out,       // Read data, one cycle after read.
    output logic            irq_out,         // Level interrupt request.
    output logic            synth_clock_sel_out, // 1: synth clock, 0: oscillator.
    output logic            osc_run_in_stop_out, // Oscillator kept in stop.
    output logic            system_clock_gate_out,     // System clocks stopped.
    output logic            core_gate_out,       // Core clock stopped.
    output logic            low_swing_out,       // Reduced amplitude request.
    output logic            synth_pwr_down_out,  // Synth powered down.
    output logic            force_auto_bw_out,   // Forces auto bandwidth to one.
    output logic            tick_hold_out,       // Tick stopped and dividers cleared.
    output logic            watchdog_hold_out    // Watchdog stopped and dividers cleared.
);
    // Status flags, enables and the select byte.
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] irq_en_reg;
    logic [7:0] clk_sel_reg;
    logic [7:0] clk_sel_next;
    logic       wdog_written_reg;      // Watchdog halt bit already written once.
    logic       settled_d_reg;         // Previous lock status for edge detect.
    logic       fallback_d_reg;        // Previous fallback status.
    cgs_mode_t  mode_reg;              // Present low-power mode.
    cgs_mode_t  mode_next;
    logic [7:0] rdata_next;

    // Address decode.
    wire wr_flags  = wr_in && (addr_in == `CGS_OFF_FLAGS);
    wire wr_irq_en = wr_in && (addr_in == `CGS_OFF_IRQ_EN);
    wire wr_sel    = wr_in && (addr_in == `CGS_OFF_CLK_SEL);

    // Synth select may only be raised with a stable synthesizer.
    wire synth_stable = auto_bw_in ? settled_in : tracking_in;

    // Hardware events that set the sticky flags; fallback_rise clears synth select.
    wire settle_chg   = settled_in ^ settled_d_reg;
    wire fallback_chg = fallback_in ^ fallback_d_reg;
    wire fallback_rise = fallback_in & ~fallback_d_reg;

    // Hardware clear of synth select on fallback rise, stop entry, or wait entry with synth halt set.
    wire hw_clr_sel = fallback_rise || enter_stop_in ||
                      (enter_wait_in && clk_sel_reg[`CGS_BIT_SYNTH_WAI]);

    // Flag update: a set in the same cycle as a clear wins.
    always_comb begin
        flags_next = flags_reg;
        if (wr_flags) begin
            flags_next = flags_reg & ~wdata_in;
        end
        if (tick_event_in) begin
            flags_next[`CGS_BIT_TICK] = 1'b1;
        end
        if (settle_chg) begin
            flags_next[`CGS_BIT_SETTLE] = 1'b1;
        end
        if (fallback_chg) begin
            flags_next[`CGS_BIT_FALLBACK] = 1'b1;
        end
        flags_next = flags_next & `CGS_IRQ_EN_MASK;
    end

    // Select byte update with per-bit write conditions.
    always_comb begin
        clk_sel_next = clk_sel_reg;
        if (wr_sel) begin
            clk_sel_next[6:1] = wdata_in[6:1];
            if (!wdata_in[`CGS_BIT_SYNTH_SEL] || synth_stable) begin
                clk_sel_next[`CGS_BIT_SYNTH_SEL] = wdata_in[`CGS_BIT_SYNTH_SEL];
            end
            if (special_mode_in || !wdog_written_reg) begin
                clk_sel_next[`CGS_BIT_WDOG_WAI] = wdata_in[`CGS_BIT_WDOG_WAI];
            end
        end
        if (hw_clr_sel) begin
            clk_sel_next[`CGS_BIT_SYNTH_SEL] = 1'b0;
        end
    end

    // Mode tracker driven by the entry and exit pulses.
    always_comb begin
        case (mode_reg)
            CGS_RUN: begin
                if (enter_stop_in) begin
                    mode_next = CGS_STOP;
                end else if (enter_wait_in) begin
                    mode_next = CGS_WAIT;
                end else begin
                    mode_next = CGS_RUN;
                end
            end
            CGS_WAIT, CGS_STOP: begin
                mode_next = exit_low_in ? CGS_RUN : mode_reg;
            end
            default: begin
                mode_next = CGS_RUN;
            end
        endcase
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        case (addr_in)
            `CGS_OFF_FLAGS:   rdata_next = flags_reg;
            `CGS_OFF_IRQ_EN:  rdata_next = irq_en_reg;
            `CGS_OFF_CLK_SEL: rdata_next = clk_sel_reg;
            `CGS_OFF_STATUS:  rdata_next = {4'h0, settled_in, tracking_in, 1'b0, fallback_in};
            default:          rdata_next = `CGS_RESET_BYTE;
        endcase
        if (!rd_in) begin
            rdata_next = `CGS_RESET_BYTE;
        end
    end

    wire in_wait = (mode_next == CGS_WAIT);
    wire in_stop = (mode_next == CGS_STOP);

    // Control registers.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_reg        <= `CGS_RESET_BYTE;
            irq_en_reg       <= `CGS_RESET_BYTE;
            clk_sel_reg      <= `CGS_RESET_BYTE;
            wdog_written_reg <= 1'b0;
            settled_d_reg    <= 1'b0;
            fallback_d_reg   <= 1'b0;
            mode_reg         <= CGS_RUN;
        end else begin
            flags_reg      <= flags_next;
            clk_sel_reg    <= clk_sel_next;
            settled_d_reg  <= settled_in;
            fallback_d_reg <= fallback_in;
            mode_reg       <= mode_next;
            if (wr_irq_en) begin
                irq_en_reg <= wdata_in & `CGS_IRQ_EN_MASK;
            end
            if (wr_sel) begin
                wdog_written_reg <= 1'b1;
            end
        end
    end

    // Registered outputs; every output comes from a flop.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out           <= `CGS_RESET_BYTE;
            irq_out             <= 1'b0;
            synth_clock_sel_out <= 1'b0;
            osc_run_in_stop_out <= 1'b0;
            system_clock_gate_out     <= 1'b0;
            core_gate_out       <= 1'b0;
            low_swing_out       <= 1'b0;
            synth_pwr_down_out  <= 1'b0;
            force_auto_bw_out   <= 1'b0;
            tick_hold_out       <= 1'b0;
            watchdog_hold_out   <= 1'b0;
        end else begin
            rdata_out           <= rdata_next;
            irq_out             <= |(flags_next & irq_en_reg);
            synth_clock_sel_out <= clk_sel_next[`CGS_BIT_SYNTH_SEL];
            osc_run_in_stop_out <= clk_sel_next[`CGS_BIT_PSEUDO];
            system_clock_gate_out     <= in_wait && clk_sel_next[`CGS_BIT_SYS_WAI];
            core_gate_out       <= in_wait && clk_sel_next[`CGS_BIT_CORE_WAI];
            low_swing_out       <= (in_wait && clk_sel_next[`CGS_BIT_LOW_SWING]) ||
                                   (in_stop && clk_sel_next[`CGS_BIT_PSEUDO]);
            synth_pwr_down_out  <= in_wait && clk_sel_next[`CGS_BIT_SYNTH_WAI];
            force_auto_bw_out   <= clk_sel_next[`CGS_BIT_SYNTH_WAI];
            tick_hold_out       <= in_wait && clk_sel_next[`CGS_BIT_TICK_WAI];
            watchdog_hold_out   <= in_wait && clk_sel_next[`CGS_BIT_WDOG_WAI];
        end
    end
endmodule // cgs_clock_select

// File: cgs_regs.svh
// Register offsets, field positions and reset values for the clock select block.
// Contract
// - Tick enable gates tick flag interrupt.
// - Settle enable gates settle change interrupt.
// - Fallback enable gates fallback change interrupt.
// - Irq enable register always read/write.
// - Synth select refused while synth unstable.
// - Synth select cleared on fallback, stop, wait with synth halt set.
// - Select chooses oscillator or synth clock.
// - Pseudo halt keeps oscillator in stop.
// - System_clock halt stops system clocks in wait.
// - Low swing requests reduced amplitude in wait.
// - Synth halt powers synth down in wait.
// - Synth halt forces auto bandwidth on.
// - Core halt stops core clock in wait.
// - Tick halt stops and resets tick dividers.
// - Watchdog halt stops and resets its dividers.
// - Watchdog halt bit write-once in normal mode.
// - Flags set on events, cleared by writing one.
`ifndef CGS_REGS_SVH
`define CGS_REGS_SVH
`define CGS_ADDR_W        4
`define CGS_OFF_FLAGS     4'h3
`define CGS_OFF_IRQ_EN    4'h4
`define CGS_OFF_CLK_SEL   4'h5
`define CGS_OFF_STATUS    4'h8
`define CGS_BIT_TICK      7
`define CGS_BIT_SETTLE    4
`define CGS_BIT_FALLBACK  1
`define CGS_BIT_SETTLED   3
`define CGS_BIT_TRACKING  2
`define CGS_BIT_FB_STAT   0
`define CGS_BIT_SYNTH_SEL 7
`define CGS_BIT_PSEUDO    6
`define CGS_BIT_SYS_WAI   5
`define CGS_BIT_LOW_SWING 4
`define CGS_BIT_SYNTH_WAI 3
`define CGS_BIT_CORE_WAI  2
`define CGS_BIT_TICK_WAI  1
`define CGS_BIT_WDOG_WAI  0
`define CGS_IRQ_EN_MASK   8'h92
`define CGS_RESET_BYTE    8'h00
`define CGS_BUS_DIV       2
`endif

// File: cgs_pkg.sv
// Types shared by the clock select block.
package cgs_pkg;
    typedef enum logic [1:0] {
        CGS_RUN  = 2'b00,
        CGS_WAIT = 2'b01,
        CGS_STOP = 2'b10
    } cgs_mode_t;
endpackage

// File: cgs_clock_select_asserts.sv
// Port-level checker for the clock select block.
`timescale 1ns/10ps
`include "cgs_regs.svh"
module cgs_clock_select_asserts (
    input wire logic       sys_clk_in,
    input wire logic       rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic       settled_in,
    input wire logic       tracking_in,
    input wire logic       auto_bw_in,
    input wire logic       fallback_in,
    input wire logic       enter_wait_in,
    input wire logic       enter_stop_in,
    input wire logic       exit_low_in,
    input wire logic [7:0] rdata_out,
    input wire logic       irq_out,
    input wire logic       synth_clock_sel_out,
    input wire logic       osc_run_in_stop_out,
    input wire logic       system_clock_gate_out,
    input wire logic       core_gate_out,
    input wire logic       synth_pwr_down_out,
    input wire logic       force_auto_bw_out,
    input wire logic       tick_hold_out,
    input wire logic       watchdog_hold_out
);
    // One clock domain, so clocking and reset are stated once.
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    irq_all_off_a: assert property (wr_in && addr_in == 4'h4 && wdata_in == 8'h00 ##1 !wr_in
        |=> !irq_out) else $error("irq stays up with all enables off");
    en_unused_zero_a: assert property (rd_in && addr_in == 4'h4
        |=> (rdata_out & ~`CGS_IRQ_EN_MASK) == 8'h00) else $error("unused enable bits read high");
    sel_refused_a: assert property (wr_in && addr_in == 4'h5 && wdata_in[7] &&
        !(auto_bw_in ? settled_in : tracking_in) && !synth_clock_sel_out |=> !synth_clock_sel_out)
        else $error("unstable synth selected");
    stop_clears_a: assert property (enter_stop_in && !wr_in ##1 !wr_in
        |=> !synth_clock_sel_out) else $error("stop entry kept synth selected");
    fb_clears_a: assert property ($rose(fallback_in) && !wr_in ##1 !wr_in
        |=> !synth_clock_sel_out) else $error("fallback kept synth selected");
    auto_bw_a: assert property (wr_in && addr_in == 4'h5
        |=> force_auto_bw_out == $past(wdata_in[3])) else $error("auto bandwidth force wrong");
    pseudo_bit_a: assert property (wr_in && addr_in == 4'h5
        |=> osc_run_in_stop_out == $past(wdata_in[6])) else $error("pseudo halt output wrong");
    exit_release_a: assert property (exit_low_in && !enter_wait_in && !enter_stop_in
        |=> !(system_clock_gate_out | core_gate_out | tick_hold_out | watchdog_hold_out
        | synth_pwr_down_out)) else $error("wait holds remain after exit");
endmodule // cgs_clock_select_asserts
bind cgs_clock_select cgs_clock_select_asserts i_cgs_clock_select_asserts (.*);

// File: cgs_clock_select_test.sv
// Self-checking bench for the clock select block.
`timescale 1ns/10ps
module cgs_clock_select_test;
    logic       sys_clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, auto_bw_in = 1'b0;
    logic       settled_in = 1'b0, tracking_in = 1'b0, fallback_in = 1'b0, tick_event_in = 1'b0;
    logic       enter_wait_in = 1'b0, enter_stop_in = 1'b0, exit_low_in = 1'b0;
    logic       special_mode_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00, rdata_out, v;
    logic       irq_out, synth_clock_sel_out, osc_run_in_stop_out, system_clock_gate_out, core_gate_out;
    logic       low_swing_out, synth_pwr_down_out, force_auto_bw_out, tick_hold_out;
    logic       watchdog_hold_out;
    int         error_cnt = 0, check_count = 0;
    wire  [4:0] gates = {system_clock_gate_out, low_swing_out, core_gate_out, tick_hold_out,
                         watchdog_hold_out};
    always #12.5 sys_clk_in = ~sys_clk_in;
    cgs_clock_select i_cgs_clock_select (.*);
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // Write, then wait one and a half cycles so registered outputs have settled.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        repeat (2) @(negedge sys_clk_in);
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask
    // One-cycle pulse: 0 tick, 1 wait entry, 2 stop entry, 3 exit.
    task automatic ev(input int k);
        @(posedge sys_clk_in);
        tick_event_in <= (k == 0);
        enter_wait_in <= (k == 1);
        enter_stop_in <= (k == 2);
        exit_low_in <= (k == 3);
        @(posedge sys_clk_in);
        {tick_event_in, enter_wait_in, enter_stop_in, exit_low_in} <= 4'h0;
        repeat (2) @(negedge sys_clk_in);
    endtask
    task automatic t_wdog;
        wr(4'h5, 8'h01);
        wr(4'h5, 8'h00);
        rd(4'h5);
        chk("wdog_once", v, 8'h01);
        @(posedge sys_clk_in) special_mode_in <= 1'b1;
        wr(4'h5, 8'h00);
        rd(4'h5);
        chk("wdog_special", v, 8'h00);
        $display("t_wdog done");
    endtask
    task automatic t_irq;
        logic [7:0] b;
        wr(4'h4, 8'hFF);
        rd(4'h4);
        chk("irq_en", v, 8'h92);
        wr(4'h4, 8'h00);
        wr(4'h4, 8'h92);
        for (int i = 0; i < 3; i++) begin
            b = (i == 0) ? 8'h80 : (i == 1) ? 8'h10 : 8'h02;
            @(posedge sys_clk_in);
            tick_event_in <= (i == 0);
            settled_in <= settled_in | (i == 1);
            fallback_in <= (i == 2);
            @(posedge sys_clk_in);
            tick_event_in <= 1'b0;
            repeat (2) @(negedge sys_clk_in);
            chk("irq_set", irq_out, 1'b1);
            rd(4'h3);
            chk("flag", v & 8'h92, b);
            wr(4'h4, 8'h92 & ~b);
            chk("irq_mask", irq_out, 1'b0);
            wr(4'h4, 8'h92);
            chk("irq_unmask", irq_out, 1'b1);
            wr(4'h3, b);
            chk("irq_clear", irq_out, 1'b0);
        end
        $display("t_irq done");
    endtask
    task automatic t_sel;
        @(posedge sys_clk_in);
        auto_bw_in <= 1'b1;
        settled_in <= 1'b0;
        wr(4'h5, 8'h80);
        chk("sel_unlocked", synth_clock_sel_out, 1'b0);
        @(posedge sys_clk_in);
        auto_bw_in <= 1'b0;
        settled_in <= 1'b1;
        wr(4'h5, 8'h80);
        chk("sel_untracked", synth_clock_sel_out, 1'b0);
        @(posedge sys_clk_in) tracking_in <= 1'b1;
        wr(4'h5, 8'h88);
        rd(4'h5);
        chk("sel_read", v, 8'h88);
        rd(4'h8);
        chk("status", v, 8'h0D);
        chk("auto_bw", force_auto_bw_out, 1'b1);
        ev(1);
        chk("sel_wait", synth_clock_sel_out, 1'b0);
        chk("synth_down", synth_pwr_down_out, 1'b1);
        ev(3);
        wr(4'h5, 8'h80);
        chk("sel_set", synth_clock_sel_out, 1'b1);
        // A fresh rise of the fallback status must drop the synth select.
        @(posedge sys_clk_in) fallback_in <= 1'b0;
        @(posedge sys_clk_in) fallback_in <= 1'b1;
        repeat (2) @(negedge sys_clk_in);
        chk("sel_fallback", synth_clock_sel_out, 1'b0);
        wr(4'h5, 8'h80);
        chk("sel_again", synth_clock_sel_out, 1'b1);
        ev(2);
        chk("sel_stop", synth_clock_sel_out, 1'b0);
        ev(3);
        $display("t_sel done");
    endtask
    task automatic t_wait;
        wr(4'h5, 8'h37);
        ev(1);
        chk("wait_gates", gates, 8'h1F);
        ev(3);
        chk("run_gates", gates, 8'h00);
        wr(4'h5, 8'h40);
        ev(2);
        chk("pseudo", {osc_run_in_stop_out, low_swing_out}, 8'h03);
        ev(3);
        $display("t_wait done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        t_wdog;
        t_irq;
        t_sel;
        t_wait;
        tally_and_finish;
    end
    // The tests need well under a thousand cycles; a hang is cut off here.
    initial begin
        #(25 * 4000);
        error_cnt++;
        tally_and_finish;
    end
endmodule // cgs_clock_select_test
